// ### core/mcuctl_params.svh
`ifndef MCUCTL_PARAMS_SVH
`define MCUCTL_PARAMS_SVH

`define MCUCTL_DATA_OFFSET      8'h55
`define MCUCTL_IO_SHIFT         8'h20
`define MCUCTL_IO_OFFSET        6'h35
`define MCUCTL_EXT_IO_BASE      8'h60
`define MCUCTL_RESET_VALUE      8'h00
`define MCUCTL_BIT_DEBUG_OFF    7
`define MCUCTL_BIT_BOD_OFF      6
`define MCUCTL_BIT_BOD_UNLOCK   5
`define MCUCTL_BIT_PULLUP_OFF   4
`define MCUCTL_BIT_VEC_SEL      1
`define MCUCTL_BIT_VEC_UNLOCK   0
`define MCUCTL_IMPL_MASK        8'hF3
`define MCUCTL_WINDOW_CYCLES    3'h4
`define MCUCTL_BOD_DELAY_CYCLES 3'h3
`define MCUCTL_BOD_HOLD_CYCLES  3'h3

`endif

// ### core/mcuctl_pkg.sv
package mcuctl_pkg;
    typedef logic [7:0] mcuctl_byte_t;
    typedef logic [2:0] mcuctl_cnt_t;
    typedef enum logic [1:0] {
        MCUCTL_BOD_IDLE  = 2'b00,
        MCUCTL_BOD_DELAY = 2'b01,
        MCUCTL_BOD_HOLD  = 2'b10
    } mcuctl_bod_state_t;
endpackage

// ### core/mcuctl_top.sv
`timescale 1ns/1ns
`include "mcuctl_params.svh"

// Summary of operation
// - register at data 0x55, I/O 0x35
// - extended space only via load/store
// - debug port on if fuse and bit zero
// - debug bit changes on repeated write within four
// - sleep-off set by unlock then write sequence
// - sleep-off effective after three, cleared three later
// - sleep with effective bit turns detector off
// - pull-up off bit disables all pull-ups
// - vector select chooses flash or boot start
// - vector select changes after unlock within four
// - unlock clears after four or on select write
// - interrupts blocked during vector change window
// - global interrupt flag left untouched
// - lock bits block interrupts in other section
// - all control bits reset to zero
module mcuctl_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic [7:0]            data_addr_i,
    input  wire logic                  data_wr_i,
    input  wire logic                  data_rd_i,
    input  wire logic [5:0]            io_addr_i,
    input  wire logic                  io_wr_i,
    input  wire logic                  io_rd_i,
    input  wire mcuctl_pkg::mcuctl_byte_t wdata_i,
    input  wire logic                  instr_done_i,
    input  wire logic                  sleep_exec_i,
    input  wire logic                  wake_i,
    input  wire logic                  debug_port_fuse_i,
    input  wire logic                  application_lock_bit_i,
    input  wire logic                  boot_lock_bit_i,
    input  wire logic                  exec_in_boot_i,
    output mcuctl_pkg::mcuctl_byte_t   rdata_o,
    output logic                       rvalid_o,
    output logic                       debug_port_enable_o,
    output logic                       brownout_detector_off_o,
    output logic                       global_pullup_off_o,
    output logic                       vector_table_select_o,
    output logic                       irq_block_o
);
    import mcuctl_pkg::*;

    mcuctl_byte_t      ctrl_reg;
    mcuctl_byte_t      ctrl_next;
    mcuctl_byte_t      rdata_reg;
    logic              rvalid_reg;
    logic              dbg_pend_val_reg;
    logic              bod_effective_reg;
    logic              bod_off_reg;
    logic              dbg_en_reg;
    logic              pullup_off_reg;
    logic              vsel_reg;
    logic              irq_block_reg;
    logic              post_sel_reg;
    logic              tail_reg;
    mcuctl_bod_state_t bod_state_reg;
    mcuctl_bod_state_t bod_state_next;
    mcuctl_cnt_t       bod_cnt_reg;
    mcuctl_cnt_t       bod_cnt_next;

    wire hit_data = data_wr_i & (data_addr_i == `MCUCTL_DATA_OFFSET);
    // short I/O addresses are 6 bits, so nothing at or above the extended base is reachable there
    wire [7:0] io_as_data = {2'b00, io_addr_i} + `MCUCTL_IO_SHIFT;
    wire io_legal  = (io_as_data < `MCUCTL_EXT_IO_BASE);
    wire hit_io    = io_wr_i & io_legal & (io_addr_i == `MCUCTL_IO_OFFSET);
    wire wr_hit    = hit_data | hit_io;
    wire rd_hit    = (data_rd_i & (data_addr_i == `MCUCTL_DATA_OFFSET))
                   | (io_rd_i & io_legal & (io_addr_i == `MCUCTL_IO_OFFSET));
    wire [7:0] wd  = wdata_i & `MCUCTL_IMPL_MASK;

    // timed windows for debug, sleep-off and vector change
    wire dbg_open;
    wire bod_open;
    wire vec_open;
    wire w_dbg     = wd[`MCUCTL_BIT_DEBUG_OFF];
    wire w_brownout_sleep_off    = wd[`MCUCTL_BIT_BOD_OFF];
    wire w_brownout_sleep_unlock   = wd[`MCUCTL_BIT_BOD_UNLOCK];
    wire w_vector_table_select   = wd[`MCUCTL_BIT_VEC_SEL];
    wire w_vector_change_unlock    = wd[`MCUCTL_BIT_VEC_UNLOCK];
    // writing the value already held arms nothing; the matching second write must land in the window
    wire dbg_arm   = wr_hit & (w_dbg != ctrl_reg[`MCUCTL_BIT_DEBUG_OFF]);
    wire dbg_take  = dbg_arm & dbg_open & (dbg_pend_val_reg == w_dbg);
    wire bod_arm   = wr_hit & w_brownout_sleep_off & w_brownout_sleep_unlock;
    wire bod_set   = wr_hit & bod_open & w_brownout_sleep_off & ~w_brownout_sleep_unlock;
    wire vec_arm   = wr_hit & w_vector_change_unlock;
    wire vec_take  = wr_hit & vec_open & ~w_vector_change_unlock;

    mcuctl_window u_dbg_win (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .arm_i    (dbg_arm & ~dbg_take),
        .cancel_i (dbg_take),
        .open_o   (dbg_open)
    );
    mcuctl_window u_bod_win (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .arm_i    (bod_arm),
        .cancel_i (bod_set),
        .open_o   (bod_open)
    );
    mcuctl_window u_vec_win (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .arm_i    (vec_arm),
        .cancel_i (vec_take),
        .open_o   (vec_open)
    );

    // sleep-off bit: delay before effective, then hold, then hardware clears it
    always_comb begin
        bod_state_next = bod_state_reg;
        bod_cnt_next   = bod_cnt_reg;
        case (bod_state_reg)
            MCUCTL_BOD_IDLE: begin
                if (bod_set) begin
                    bod_state_next = MCUCTL_BOD_DELAY;
                    bod_cnt_next   = `MCUCTL_BOD_DELAY_CYCLES - 3'h1;
                end
            end
            MCUCTL_BOD_DELAY: begin
                if (bod_cnt_reg == 3'h1) begin
                    bod_state_next = MCUCTL_BOD_HOLD;
                    bod_cnt_next   = `MCUCTL_BOD_HOLD_CYCLES;
                end else begin
                    bod_cnt_next = bod_cnt_reg - 3'h1;
                end
            end
            MCUCTL_BOD_HOLD: begin
                if (bod_cnt_reg == 3'h1) begin
                    bod_state_next = MCUCTL_BOD_IDLE;
                    bod_cnt_next   = 3'h0;
                end else begin
                    bod_cnt_next = bod_cnt_reg - 3'h1;
                end
            end
            default: begin
                bod_state_next = MCUCTL_BOD_IDLE;
                bod_cnt_next   = 3'h0;
            end
        endcase
    end

    wire brownout_sleep_off_bit = (bod_state_next != MCUCTL_BOD_IDLE);

    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next[`MCUCTL_BIT_BOD_OFF]    = brownout_sleep_off_bit;
        ctrl_next[`MCUCTL_BIT_BOD_UNLOCK] = bod_arm | (bod_open & ~bod_set & ~(wr_hit & ~w_brownout_sleep_unlock));
        ctrl_next[`MCUCTL_BIT_VEC_UNLOCK] = vec_arm | (vec_open & ~vec_take);
        if (wr_hit) begin
            ctrl_next[`MCUCTL_BIT_PULLUP_OFF] = wd[`MCUCTL_BIT_PULLUP_OFF];
        end
        if (dbg_take) begin
            ctrl_next[`MCUCTL_BIT_DEBUG_OFF] = w_dbg;
        end
        if (vec_take) begin
            ctrl_next[`MCUCTL_BIT_VEC_SEL] = w_vector_table_select;
        end
    end

    // block spans unlock, open window, the select write and the instruction after it
    wire blk_vec  = vec_arm | (vec_open & ~vec_take) | vec_take | post_sel_reg;
    wire blk_lock = (ctrl_next[`MCUCTL_BIT_VEC_SEL] & application_lock_bit_i & ~exec_in_boot_i)
                  | (~ctrl_next[`MCUCTL_BIT_VEC_SEL] & boot_lock_bit_i & exec_in_boot_i);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg          <= `MCUCTL_RESET_VALUE;
            bod_state_reg     <= MCUCTL_BOD_IDLE;
            bod_cnt_reg       <= 3'h0;
            dbg_pend_val_reg  <= 1'b0;
            bod_effective_reg <= 1'b0;
            bod_off_reg       <= 1'b0;
            dbg_en_reg        <= 1'b0;
            pullup_off_reg    <= 1'b0;
            vsel_reg          <= 1'b0;
            irq_block_reg     <= 1'b0;
            post_sel_reg      <= 1'b0;
            tail_reg          <= 1'b0;
            rdata_reg         <= 8'h00;
            rvalid_reg        <= 1'b0;
        end else begin
            ctrl_reg          <= ctrl_next;
            bod_state_reg     <= bod_state_next;
            bod_cnt_reg       <= bod_cnt_next;
            dbg_pend_val_reg  <= dbg_arm ? w_dbg : dbg_pend_val_reg;
            bod_effective_reg <= (bod_state_next == MCUCTL_BOD_HOLD);
            // detector stays off until wake, only if sleep began while effective
            if (sleep_exec_i & bod_effective_reg) begin
                bod_off_reg <= 1'b1;
            end else if (wake_i) begin
                bod_off_reg <= 1'b0;
            end
            dbg_en_reg        <= debug_port_fuse_i & ~ctrl_next[`MCUCTL_BIT_DEBUG_OFF];
            pullup_off_reg    <= ctrl_next[`MCUCTL_BIT_PULLUP_OFF];
            vsel_reg          <= ctrl_next[`MCUCTL_BIT_VEC_SEL];
            // hold the block through the instruction after the select write
            post_sel_reg      <= vec_take | (post_sel_reg & ~tail_reg);
            tail_reg          <= post_sel_reg & instr_done_i;
            irq_block_reg     <= blk_vec | blk_lock;
            // zero when not addressed, so answers of several registers can be or-ed together
            rdata_reg         <= rd_hit ? (ctrl_reg & `MCUCTL_IMPL_MASK) : 8'h00;
            rvalid_reg        <= rd_hit;
        end
    end

    assign rdata_o                 = rdata_reg;
    assign rvalid_o                = rvalid_reg;
    assign debug_port_enable_o     = dbg_en_reg;
    assign brownout_detector_off_o = bod_off_reg;
    assign global_pullup_off_o     = pullup_off_reg;
    assign vector_table_select_o   = vsel_reg;
    assign irq_block_o             = irq_block_reg;
endmodule

// ### core/mcuctl_window.sv
`timescale 1ns/1ns
`include "mcuctl_params.svh"

// armed by arm_i, counts down a window of WINDOW_CYCLES cycles; cancel_i closes it early
module mcuctl_window #(
    parameter logic [2:0] WINDOW_CYCLES = `MCUCTL_WINDOW_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic arm_i,
    input  wire logic cancel_i,
    output logic      open_o
);
    import mcuctl_pkg::*;

    mcuctl_cnt_t cnt_reg;
    mcuctl_cnt_t cnt_next;

    // re-arming restarts the full window
    assign cnt_next = arm_i    ? WINDOW_CYCLES :
                      cancel_i ? 3'h0 :
                      (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : 3'h0;
    assign open_o   = (cnt_reg != 3'h0);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ### test/mcuctl_top_properties.sv
`timescale 1ns/1ns
module mcuctl_props (
    input wire logic                     clk_i,
    input wire logic                     rst_n_i,
    input wire logic [7:0]               data_addr_i,
    input wire logic                     data_wr_i,
    input wire logic                     data_rd_i,
    input wire logic [5:0]               io_addr_i,
    input wire logic                     io_wr_i,
    input wire logic                     io_rd_i,
    input wire mcuctl_pkg::mcuctl_byte_t wdata_i,
    input wire logic                     sleep_exec_i,
    input wire logic                     wake_i,
    input wire logic                     debug_port_fuse_i,
    input wire logic                     application_lock_bit_i,
    input wire logic                     boot_lock_bit_i,
    input wire mcuctl_pkg::mcuctl_byte_t rdata_o,
    input wire logic                     rvalid_o,
    input wire logic                     debug_port_enable_o,
    input wire logic                     brownout_detector_off_o,
    input wire logic                     global_pullup_off_o,
    input wire logic                     vector_table_select_o,
    input wire logic                     irq_block_o
);
    import mcuctl_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic wr_hit = (data_wr_i && data_addr_i == 8'h55) || (io_wr_i && io_addr_i == 6'h35);
    wire logic rd_hit = (data_rd_i && data_addr_i == 8'h55) || (io_rd_i && io_addr_i == 6'h35);
    wire logic unlock = wr_hit && wdata_i[1:0] == 2'b01;
    wire logic quiet  = !wr_hit && !application_lock_bit_i && !boot_lock_bit_i;
    property p_rd; rd_hit |=> rvalid_o && rdata_o[3:2] == 2'b00; endproperty
    a_rd: assert property (p_rd) else $error("read answer wrong");
    property p_nohit; !rd_hit |=> rdata_o == 8'h00; endproperty
    a_nohit: assert property (p_nohit) else $error("data without a hit");
    property p_dbg; debug_port_enable_o |-> $past(debug_port_fuse_i); endproperty
    a_dbg: assert property (p_dbg) else $error("debug port on without fuse");
    property p_pud; $changed(global_pullup_off_o) |-> $past(wr_hit) || $past(wr_hit, 2); endproperty
    a_pud: assert property (p_pud) else $error("pull-up off moved without write");
    property p_vsel; $changed(vector_table_select_o) |-> $past(wr_hit) || $past(wr_hit, 2); endproperty
    a_vsel: assert property (p_vsel) else $error("vector select moved without write");
    property p_blk; unlock |-> ##[1:2] irq_block_o; endproperty
    a_blk: assert property (p_blk) else $error("no block after unlock");
    property p_blk_end; unlock ##1 quiet [*8] |=> !irq_block_o; endproperty
    a_blk_end: assert property (p_blk_end) else $error("block outlived window");
    property p_bod_on; $rose(brownout_detector_off_o) |-> $past(sleep_exec_i) || $past(sleep_exec_i, 2); endproperty
    a_bod_on: assert property (p_bod_on) else $error("detector off without sleep");
    property p_bod_off; wake_i && !sleep_exec_i |-> ##[1:2] !brownout_detector_off_o; endproperty
    a_bod_off: assert property (p_bod_off) else $error("detector stayed off after wake");
    c_unlock: cover property (unlock);
    c_bod: cover property ($rose(brownout_detector_off_o));
    c_dbg: cover property ($fell(debug_port_enable_o));
endmodule

// ### test/mcuctl_top_test.sv
`timescale 1ns/1ns
module mcuctl_top_test;
    import mcuctl_pkg::*;
    logic         clk_i = 0, rst_n_i = 0, data_wr_i = 0, data_rd_i = 0, io_wr_i = 0, io_rd_i = 0;
    logic         instr_done_i = 0, sleep_exec_i = 0, wake_i = 0, debug_port_fuse_i = 1, exec_in_boot_i = 0;
    logic         application_lock_bit_i = 0, boot_lock_bit_i = 0;
    logic [7:0]   data_addr_i = 8'h00;
    logic [5:0]   io_addr_i = 6'h00;
    mcuctl_byte_t wdata_i = 8'h00, rdata_o;
    logic         rvalid_o, debug_port_enable_o, brownout_detector_off_o;
    logic         global_pullup_off_o, vector_table_select_o, irq_block_o;
    int           n_mismatch = 0, compares = 0, cyc = 0;
    mcuctl_top i_mcuctl_top (.*);
    always #5 clk_i = ~clk_i;
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one idle cycle after each strobe so no signal is driven twice in a time step
    task wr(input logic [7:0] a, input mcuctl_byte_t d, input bit io);
        wdata_i = d;
        if (io) begin io_addr_i = a[5:0]; io_wr_i = 1; end
        else begin data_addr_i = a; data_wr_i = 1; end
        step(1);
        io_wr_i = 0;
        data_wr_i = 0;
        step(1);
    endtask
    task rd(input bit io, input mcuctl_byte_t exp);
        if (io) begin io_addr_i = 6'h35; io_rd_i = 1; end
        else begin data_addr_i = 8'h55; data_rd_i = 1; end
        step(1);
        chk(rvalid_o, 8'h01);
        chk(rdata_o, exp);
        io_rd_i = 0;
        data_rd_i = 0;
        step(1);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        step(1);
        s = 0;
    endtask
    task te(input string s);
        $display("test %s done", s);
    endtask
    // only implemented bits survive; 3 and 2 always read back as zero
    function automatic mcuctl_byte_t vis(input mcuctl_byte_t w);
        return w & 8'hF3;
    endfunction
    initial begin
        mcuctl_byte_t w;
        bit io;
        void'($urandom(58361));
        step(4);
        rst_n_i = 1;
        rd(0, 8'h00); rd(1, 8'h00);
        chk(debug_port_enable_o, 8'h01);
        te("reset");
        for (int i = 0; i < 20; i++) begin
            w = $urandom & 8'h1C;
            io = $urandom;
            wr(io ? 8'h35 : 8'h55, w, io);
            rd(~io, vis(w));
            chk(global_pullup_off_o, w[4]);
        end
        wr(8'h55, 8'h00, 0); wr(8'h75, 8'h10, 0); wr(8'h35, 8'h10, 0); wr(8'h15, 8'h10, 1);
        rd(0, 8'h00);
        te("random and unmapped");
        wr(8'h55, 8'h80, 0); step(6); rd(0, 8'h00);
        wr(8'h55, 8'h80, 0); wr(8'h35, 8'h80, 1); rd(0, 8'h80);
        chk(debug_port_enable_o, 8'h00);
        wr(8'h55, 8'h00, 0); wr(8'h55, 8'h00, 0);
        chk(debug_port_enable_o, 8'h01);
        debug_port_fuse_i = 0; step(2); chk(debug_port_enable_o, 8'h00);
        debug_port_fuse_i = 1;
        te("debug");
        wr(8'h35, 8'h01, 1); chk(irq_block_o, 8'h01);
        wr(8'h55, 8'h02, 0); chk(vector_table_select_o, 8'h01);
        rd(0, 8'h02); chk(irq_block_o, 8'h01);
        pulse(instr_done_i); step(4); chk(irq_block_o, 8'h00);
        wr(8'h55, 8'h00, 0); step(2); chk(vector_table_select_o, 8'h01);
        wr(8'h55, 8'h01, 0); step(8); wr(8'h55, 8'h00, 0); rd(0, 8'h02);
        chk(irq_block_o, 8'h00);
        te("vector");
        application_lock_bit_i = 1; step(3); chk(irq_block_o, 8'h01);
        exec_in_boot_i = 1; step(3); chk(irq_block_o, 8'h00);
        application_lock_bit_i = 0; boot_lock_bit_i = 1; step(3); chk(irq_block_o, 8'h00);
        boot_lock_bit_i = 0; exec_in_boot_i = 0;
        te("lock");
        wr(8'h55, 8'h40, 0); pulse(sleep_exec_i); step(2);
        chk(brownout_detector_off_o, 8'h00);
        pulse(wake_i); step(6);
        wr(8'h55, 8'h60, 0); wr(8'h55, 8'h40, 0); rd(0, 8'h42);
        pulse(sleep_exec_i); step(2); chk(brownout_detector_off_o, 8'h01);
        pulse(wake_i); step(2); chk(brownout_detector_off_o, 8'h00);
        step(6); rd(0, 8'h02);
        te("sleep");
        report_and_stop();
    end
endmodule
bind mcuctl_top mcuctl_props i_mcuctl_props (.*);
